//--- hdl/ils_chan.sv
// One injector low-side channel: switching, over-current filter, off-state diagnosis.
// Assumes comparator inputs are already synchronised to clk.
`timescale 1ns/1ps
module ils_chan
    import ils_pkg::*;
#(
    parameter int DIAG_CYC = DIAG_FILT_CYC,
    parameter int MSK_CYC  = MASK_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic cmd_on,
    input  wire logic ovc_det,
    input  wire logic ol_det,
    input  wire logic sg_det,
    input  wire logic flag_clr,
    output logic      drive_reg,
    output logic      fast_off_reg,
    output logic      ovc_flag_reg,
    output logic      ol_flag_reg,
    output logic      sg_flag_reg
);

    localparam logic [CNT_W-1:0] OVC_END  = CNT_W'(OVC_FILT_CYC - 1);
    localparam logic [CNT_W-1:0] DIAG_END = CNT_W'(DIAG_CYC - 1);
    localparam logic [CNT_W-1:0] MSK_END  = CNT_W'(MSK_CYC - 1);

    ils_chan_st_t     st_reg, st_next;
    logic [CNT_W-1:0] tmr_reg, tmr_next;
    logic [CNT_W-1:0] ol_cnt_reg, ol_cnt_next;
    logic [CNT_W-1:0] sg_cnt_reg, sg_cnt_next;
    logic             drive_next, fast_off_next;
    logic             ovc_flag_next, ol_flag_next, sg_flag_next;
    logic             ovc_trip, ol_trip, sg_trip;

    // Saturating counter step while a condition holds
    function automatic logic [CNT_W-1:0] count_up(input logic hold, input logic [CNT_W-1:0] c);
        count_up = !hold ? CNT_RST : (c == {CNT_W{1'b1}}) ? c : c + CNT_W'(1);
    endfunction

    // ========================================================================
    // State and counters
    always_comb begin
        st_next     = st_reg;
        tmr_next    = tmr_reg;
        ol_cnt_next = CNT_RST;
        sg_cnt_next = CNT_RST;
        ovc_trip    = 1'b0;
        ol_trip     = 1'b0;
        sg_trip     = 1'b0;
        unique case (st_reg)
            ILS_ON: begin
                tmr_next = count_up(ovc_det, tmr_reg);
                if (ovc_det && tmr_reg == OVC_END) begin
                    ovc_trip = 1'b1;
                    st_next  = ILS_FAULT;
                end else if (!cmd_on) begin
                    st_next  = ILS_OFF_MASK;
                    tmr_next = CNT_RST;
                end
            end
            ILS_FAULT: begin
                // Stays off until the command is withdrawn
                tmr_next = CNT_RST;
                if (!cmd_on) begin
                    st_next = ILS_OFF_MASK;
                end
            end
            ILS_OFF_MASK: begin
                tmr_next = tmr_reg + CNT_W'(1);
                if (cmd_on) begin
                    st_next  = ILS_ON;
                    tmr_next = CNT_RST;
                end else if (tmr_reg == MSK_END) begin
                    st_next  = ILS_OFF_DIAG;
                    tmr_next = CNT_RST;
                end
            end
            ILS_OFF_DIAG: begin
                ol_cnt_next = count_up(ol_det, ol_cnt_reg);
                sg_cnt_next = count_up(sg_det, sg_cnt_reg);
                ol_trip     = ol_det && ol_cnt_reg == DIAG_END;
                sg_trip     = sg_det && sg_cnt_reg == DIAG_END;
                if (cmd_on) begin
                    st_next = ILS_ON;
                end
            end
        endcase
        drive_next    = (st_next == ILS_ON);
        fast_off_next = (st_next == ILS_FAULT);
        // Set wins over clear
        ovc_flag_next = ovc_trip | (ovc_flag_reg & ~flag_clr);
        ol_flag_next  = ol_trip | (ol_flag_reg & ~flag_clr);
        sg_flag_next  = sg_trip | (sg_flag_reg & ~flag_clr);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg       <= ILS_OFF_MASK;
            tmr_reg      <= CNT_RST;
            ol_cnt_reg   <= CNT_RST;
            sg_cnt_reg   <= CNT_RST;
            drive_reg    <= 1'b0;
            fast_off_reg <= 1'b0;
            ovc_flag_reg <= 1'b0;
            ol_flag_reg  <= 1'b0;
            sg_flag_reg  <= 1'b0;
        end else begin
            st_reg       <= st_next;
            tmr_reg      <= tmr_next;
            ol_cnt_reg   <= ol_cnt_next;
            sg_cnt_reg   <= sg_cnt_next;
            drive_reg    <= drive_next;
            fast_off_reg <= fast_off_next;
            ovc_flag_reg <= ovc_flag_next;
            ol_flag_reg  <= ol_flag_next;
            sg_flag_reg  <= sg_flag_next;
        end
    end

    // ========================================================================
    // Checks
    ovc_trip_a: assert property (@(posedge clk) disable iff (rst)
        st_reg == ILS_ON && ovc_det && tmr_reg == OVC_END |=> !drive_reg && fast_off_reg)
        else $error("over-current did not force fast switch-off");
    ovc_filter_a: assert property (@(posedge clk) disable iff (rst)
        $rose(fast_off_reg) |-> $past(tmr_reg) == OVC_END && $past(ovc_det))
        else $error("over-current tripped before filter time");
    ol_filter_a: assert property (@(posedge clk) disable iff (rst)
        $rose(ol_flag_reg) |-> $past(ol_cnt_reg) == DIAG_END && $past(ol_det))
        else $error("open-load reported before filter time");
    sg_filter_a: assert property (@(posedge clk) disable iff (rst)
        $rose(sg_flag_reg) |-> $past(sg_cnt_reg) == DIAG_END && $past(sg_det))
        else $error("short-to-ground reported before filter time");
    diag_mask_a: assert property (@(posedge clk) disable iff (rst)
        st_reg == ILS_OFF_MASK |-> ol_cnt_reg == CNT_RST && sg_cnt_reg == CNT_RST && !drive_reg)
        else $error("diagnosis ran during mask interval");
    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
        ovc_flag_reg && !flag_clr |=> ovc_flag_reg)
        else $error("over-current flag lost without clear");

endmodule

//--- hdl/ils_ctrl.sv
// Top of the injector low-side driver control: serial link, gating and five channels.
// Assumes link pins and comparator outputs are asynchronous to clk.
`timescale 1ns/1ps
module ils_ctrl
    import ils_pkg::*;
#(
    parameter int DIAG_CYC = DIAG_FILT_CYC,
    parameter int MSK_CYC  = MASK_CYC
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           internal_device_reset_line,
    input  wire logic           link_clk,
    input  wire logic           link_en,
    input  wire logic           link_din,
    output logic                link_dout,
    input  wire logic [NCH-1:0] ovc_det,
    input  wire logic [NCH-1:0] ol_det,
    input  wire logic [NCH-1:0] sg_det,
    output logic [NCH-1:0]      injector_lowside_output,
    output logic [NCH-1:0]      fast_off,
    output logic                global_outputs_disable_bit
);

    // ========================================================================
    // Synchronisers
    logic [2:0]           sclk_sy_reg, en_sy_reg;
    logic [1:0]           din_sy_reg, drst_sy_reg;
    logic [NCH-1:0]       ovc_m_reg, ovc_s_reg;
    logic [NCH-1:0]       ol_m_reg, ol_s_reg;
    logic [NCH-1:0]       sg_m_reg, sg_s_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_sy_reg <= 3'h0;
            en_sy_reg   <= 3'h0;
            din_sy_reg  <= 2'h0;
            drst_sy_reg <= 2'h3;
            ovc_m_reg   <= '0;
            ovc_s_reg   <= '0;
            ol_m_reg    <= '0;
            ol_s_reg    <= '0;
            sg_m_reg    <= '0;
            sg_s_reg    <= '0;
        end else begin
            sclk_sy_reg <= {sclk_sy_reg[1:0], link_clk};
            en_sy_reg   <= {en_sy_reg[1:0], link_en};
            din_sy_reg  <= {din_sy_reg[0], link_din};
            drst_sy_reg <= {drst_sy_reg[0], internal_device_reset_line};
            ovc_m_reg   <= ovc_det;
            ovc_s_reg   <= ovc_m_reg;
            ol_m_reg    <= ol_det;
            ol_s_reg    <= ol_m_reg;
            sg_m_reg    <= sg_det;
            sg_s_reg    <= sg_m_reg;
        end
    end

    logic sclk_rise, sclk_fall, en_rise, en_fall, en_s, din_s, drst_s;

    assign sclk_rise = sclk_sy_reg[1] & ~sclk_sy_reg[2];
    assign sclk_fall = ~sclk_sy_reg[1] & sclk_sy_reg[2];
    assign en_s      = en_sy_reg[1];
    assign en_rise   = en_sy_reg[1] & ~en_sy_reg[2];
    assign en_fall   = ~en_sy_reg[1] & en_sy_reg[2];
    assign din_s     = din_sy_reg[1];
    assign drst_s    = drst_sy_reg[1];

    // ========================================================================
    // Link frame handling
    logic [CMD_BITS-1:0]  cmd_sh_reg, cmd_sh_next;
    logic [BITCNT_W-1:0]  bit_cnt_reg, bit_cnt_next;
    logic [NCH-1:0]       ch_cmd_reg, ch_cmd_next;
    logic                 dis_reg, dis_next;
    logic [DIAG_BITS-1:0] up_sh_reg, up_sh_next;
    logic [DIAG_BITS-1:0] diag_vec;
    logic                 frame_ok;

    assign frame_ok = en_fall && bit_cnt_reg == BITCNT_W'(CMD_BITS);

    always_comb begin
        cmd_sh_next  = cmd_sh_reg;
        bit_cnt_next = bit_cnt_reg;
        ch_cmd_next  = ch_cmd_reg;
        dis_next     = dis_reg;
        up_sh_next   = up_sh_reg;
        if (en_rise) begin
            // Flags are snapshot for upstream and cleared in the channels
            bit_cnt_next = '0;
            up_sh_next   = diag_vec;
        end else if (en_s) begin
            if (sclk_rise) begin
                cmd_sh_next = {cmd_sh_reg[CMD_BITS-2:0], din_s};
                if (bit_cnt_reg != {BITCNT_W{1'b1}}) begin
                    bit_cnt_next = bit_cnt_reg + BITCNT_W'(1);
                end
            end
            if (sclk_fall) begin
                up_sh_next = {up_sh_reg[DIAG_BITS-2:0], 1'b0};
            end
        end
        // Only a complete frame of exact length is applied
        if (frame_ok) begin
            ch_cmd_next = cmd_sh_reg[NCH-1:0];
            dis_next    = cmd_sh_reg[CMD_DIS_POS];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_sh_reg  <= CMD_RST;
            bit_cnt_reg <= '0;
            ch_cmd_reg  <= '0;
            dis_reg     <= 1'b0;
            up_sh_reg   <= DIAG_RST;
        end else begin
            cmd_sh_reg  <= cmd_sh_next;
            bit_cnt_reg <= bit_cnt_next;
            ch_cmd_reg  <= ch_cmd_next;
            dis_reg     <= dis_next;
            up_sh_reg   <= up_sh_next;
        end
    end

    assign link_dout                  = up_sh_reg[DIAG_BITS-1];
    assign global_outputs_disable_bit = dis_reg;

    // ========================================================================
    // Channels
    logic [NCH-1:0] cmd_gated, drive;

    assign cmd_gated = ch_cmd_reg & {NCH{~(dis_reg | drst_s)}};

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        ils_chan #(
            .DIAG_CYC (DIAG_CYC),
            .MSK_CYC  (MSK_CYC)
        ) u_chan (
            .clk          (clk),
            .rst          (rst),
            .cmd_on       (cmd_gated[i]),
            .ovc_det      (ovc_s_reg[i]),
            .ol_det       (ol_s_reg[i]),
            .sg_det       (sg_s_reg[i]),
            .flag_clr     (en_rise),
            .drive_reg    (drive[i]),
            .fast_off_reg (fast_off[i]),
            .ovc_flag_reg (diag_vec[i*DIAG_PER_CH+DIAG_OVC_POS]),
            .ol_flag_reg  (diag_vec[i*DIAG_PER_CH+DIAG_OL_POS]),
            .sg_flag_reg  (diag_vec[i*DIAG_PER_CH+DIAG_SG_POS])
        );
    end

    assign injector_lowside_output = drive;

    // ========================================================================
    // Checks
    sequence force_held_s;
        (dis_reg || drst_s) [*2];
    endsequence

    force_off_a: assert property (@(posedge clk) disable iff (rst)
        force_held_s |-> injector_lowside_output == '0)
        else $error("output on while reset or disable active");
    cmd_apply_a: assert property (@(posedge clk) disable iff (rst)
        frame_ok |=> ch_cmd_reg == $past(cmd_sh_reg[NCH-1:0]) && dis_reg == $past(cmd_sh_reg[CMD_DIS_POS]))
        else $error("command frame not applied");
    cmd_stable_a: assert property (@(posedge clk) disable iff (rst)
        !frame_ok |=> $stable(ch_cmd_reg))
        else $error("channel command changed outside a frame end");
    up_load_a: assert property (@(posedge clk) disable iff (rst)
        en_rise |=> up_sh_reg == $past(diag_vec))
        else $error("diagnosis flags not loaded at frame start");
    on_needs_cmd_a: assert property (@(posedge clk) disable iff (rst)
        $rose(injector_lowside_output[0]) |-> $past(cmd_gated[0]))
        else $error("channel switched on without command");

    // Command paths from frame end to output, first and last channel
    sequence ch0_on_s;
        frame_ok && cmd_sh_reg[0] && !cmd_sh_reg[CMD_DIS_POS] ##1 !drst_s;
    endsequence

    sequence last_on_s;
        frame_ok && cmd_sh_reg[NCH-1] && !cmd_sh_reg[CMD_DIS_POS] ##1 !drst_s;
    endsequence

    sequence ch0_off_s;
        frame_ok && !cmd_sh_reg[0];
    endsequence

    ch0_on_a: assert property (@(posedge clk) disable iff (rst)
        ch0_on_s |=> injector_lowside_output[0] || fast_off[0])
        else $error("channel 0 not switched on by command");
    last_ch_on_a: assert property (@(posedge clk) disable iff (rst)
        last_on_s |=> injector_lowside_output[NCH-1] || fast_off[NCH-1])
        else $error("last channel not switched on by command");
    ch0_off_a: assert property (@(posedge clk) disable iff (rst)
        ch0_off_s |-> ##2 !injector_lowside_output[0])
        else $error("channel 0 not switched off by command");
    dev_reset_off_a: assert property (@(posedge clk) disable iff (rst)
        drst_s |=> injector_lowside_output == '0)
        else $error("output on during device reset");
    disable_off_a: assert property (@(posedge clk) disable iff (rst)
        dis_reg |=> injector_lowside_output == '0)
        else $error("output on while outputs disabled");
    frame_reject_a: assert property (@(posedge clk) disable iff (rst)
        en_fall && bit_cnt_reg != BITCNT_W'(CMD_BITS) |=> $stable(ch_cmd_reg) && $stable(dis_reg))
        else $error("frame of wrong length was applied");
    up_shift_a: assert property (@(posedge clk) disable iff (rst)
        en_s && !en_rise && sclk_fall |=> up_sh_reg == {$past(up_sh_reg[DIAG_BITS-2:0]), 1'b0})
        else $error("upstream diagnosis not shifted");
    fast_excl_a: assert property (@(posedge clk) disable iff (rst)
        (fast_off & injector_lowside_output) == '0)
        else $error("channel on while fast switch-off selected");

endmodule

//--- hdl/ils_pkg.sv
// Constants shared by the injector low-side driver control logic.
// Assumes a 100 MHz core clock; all times are converted to cycles here.
package ils_pkg;

    // ========================================================================
    // Channels and clock
    localparam int NCH           = 5;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CNT_W         = 16;

    // ========================================================================
    // Filter and masking times
    localparam int OVC_FILT_NS   = 3000;
    localparam int OVC_FILT_CYC  = OVC_FILT_NS / CLK_PERIOD_NS;
    localparam int DIAG_FILT_US  = 50;
    localparam int DIAG_FILT_CYC = (DIAG_FILT_US * 1000) / CLK_PERIOD_NS;
    localparam int MASK_US       = 400;
    localparam int MASK_CYC      = (MASK_US * 1000) / CLK_PERIOD_NS;

    // ========================================================================
    // Serial link frames
    localparam int CMD_BITS      = 8;
    localparam int CMD_DIS_POS   = 7;
    localparam int BITCNT_W      = 5;
    localparam int DIAG_PER_CH   = 3;
    localparam int DIAG_BITS     = NCH * DIAG_PER_CH;
    localparam int DIAG_OVC_POS  = 0;
    localparam int DIAG_OL_POS   = 1;
    localparam int DIAG_SG_POS   = 2;

    // ========================================================================
    // Reset values
    localparam logic [CMD_BITS-1:0]  CMD_RST  = 8'h00;
    localparam logic [DIAG_BITS-1:0] DIAG_RST = 15'h0000;
    localparam logic [CNT_W-1:0]     CNT_RST  = 16'h0000;

    typedef enum logic [1:0] {
        ILS_OFF_MASK,
        ILS_OFF_DIAG,
        ILS_ON,
        ILS_FAULT
    } ils_chan_st_t;

endpackage

//--- verif/ils_mcu_model.sv
// Behavioural microcontroller on the far side of the serial link.
// Assumes a running core clock; frames start just after a falling core edge.
`timescale 1ns/1ps
module ils_mcu_model (
    input  wire logic clk,
    output logic      link_clk,
    output logic      link_en,
    output logic      link_din,
    input  wire logic link_dout
);
    // ========================================================================
    // Idle link: clock stands low, no frame
    initial begin
        link_clk = 1'b0;
        link_en  = 1'b0;
        link_din = 1'b0;
    end

    // ========================================================================
    // One frame of nbits, MSB first; upstream bits collected into rx
    task automatic frame(input int nbits, input logic [14:0] data, output logic [14:0] rx);
        rx = 15'h0000;
        @(negedge clk);
        #1 link_en = 1'b1;
        for (int i = nbits - 1; i >= 0; i--) begin
            link_din = data[i];
            #62.5;
            rx = {rx[13:0], link_dout};
            link_clk = 1'b1;
            #62.5;
            link_clk = 1'b0;
        end
        #62.5;
        link_en  = 1'b0;
        // Released data line shows no stale value
        link_din = ~link_din;
        #62.5;
    endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the injector low-side driver control.
// Assumes the microcontroller model drives the link; short mask and off-state diagnosis filter times.
`timescale 1ns/1ps
module tb
    import ils_pkg::*;
;

    // ========================================================================
    // Signals and model state
    localparam int T_DIAG = 20;
    localparam int T_MASK = 40;
    logic           clk;
    logic           rst;
    logic           internal_device_reset_line;
    logic           link_clk;
    logic           link_en;
    logic           link_din;
    logic           link_dout;
    logic [NCH-1:0] ovc_det;
    logic [NCH-1:0] ol_det;
    logic [NCH-1:0] sg_det;
    logic [NCH-1:0] injector_lowside_output;
    logic [NCH-1:0] fast_off;
    logic           global_outputs_disable_bit;
    logic [14:0]    rx;
    logic [31:0]    v;
    int             m_cmd;
    int             m_dis;
    int             m_trip;
    int             n_fail;
    int             n_checks;
    int             cycles;
    int             seed = 82;

    ils_ctrl #(.DIAG_CYC(T_DIAG), .MSK_CYC(T_MASK)) u_ils_ctrl (
        .clk(clk), .rst(rst), .internal_device_reset_line(internal_device_reset_line),
        .link_clk(link_clk), .link_en(link_en), .link_din(link_din), .link_dout(link_dout),
        .ovc_det(ovc_det), .ol_det(ol_det), .sg_det(sg_det),
        .injector_lowside_output(injector_lowside_output), .fast_off(fast_off),
        .global_outputs_disable_bit(global_outputs_disable_bit)
    );

    ils_mcu_model u_ils_mcu_model (
        .clk(clk), .link_clk(link_clk), .link_en(link_en), .link_din(link_din), .link_dout(link_dout)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // ========================================================================
    // Tasks
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Expected pins from the model: disable gates all, a trip latches off
    task automatic check_state();
        logic [NCH-1:0] e;
        e = (m_dis != 0) ? 5'h00 : NCH'(m_cmd & ~m_trip);
        check({4'h0, fast_off, global_outputs_disable_bit, injector_lowside_output},
              {4'h0, NCH'(m_trip), 1'(m_dis), e});
    endtask

    task automatic send(input logic [7:0] cmd);
        u_ils_mcu_model.frame(8, {7'h00, cmd}, rx);
        m_cmd  = int'(cmd[4:0]);
        m_dis  = int'(cmd[7]);
        m_trip = (cmd[7] == 1'b1) ? 0 : (m_trip & m_cmd);
        wait_clk(10);
    endtask

    task automatic read_diag(input logic [14:0] exp);
        u_ils_mcu_model.frame(15, 15'h0000, rx);
        check(rx, exp);
        wait_clk(4);
    endtask

    // ========================================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        internal_device_reset_line = 1'b0;
        ovc_det = '0;
        ol_det  = '0;
        sg_det  = '0;
        {m_cmd, m_dis, m_trip, n_fail, n_checks, cycles} = '0;
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        wait_clk(3);
        check_state();
        check({14'h0000, link_dout}, 15'h0000);
        for (int ch = 0; ch <= NCH; ch++) begin
            send((ch < NCH) ? 8'(1 << ch) : 8'h9f);
            check_state();
        end
        repeat (6) begin
            v = $random(seed);
            send(v[7:0]);
            check_state();
        end
        u_ils_mcu_model.frame(7, 15'h007f, rx);
        u_ils_mcu_model.frame(9, 15'h01ff, rx);
        wait_clk(10);
        check_state();
        send(8'h1f);
        internal_device_reset_line = 1'b1;
        wait_clk(6);
        check({10'h000, injector_lowside_output}, 15'h0000);
        internal_device_reset_line = 1'b0;
        send(8'h00);
        check_state();
        // Over-current filter restarts after a gap, then trips
        send(8'h01);
        ovc_det[0] = 1'b1;
        wait_clk(200);
        ovc_det[0] = 1'b0;
        wait_clk(5);
        ovc_det[0] = 1'b1;
        wait_clk(280);
        check_state();
        wait_clk(40);
        m_trip = 1;
        check_state();
        ovc_det[0] = 1'b0;
        read_diag(15'h0001);
        send(8'h00);
        check_state();
        // Off-state diagnosis: short glitch filtered, held fault flagged
        wait_clk(T_MASK + T_DIAG);
        read_diag(15'h0000);
        ol_det[3] = 1'b1;
        wait_clk(T_DIAG - 8);
        ol_det[3] = 1'b0;
        read_diag(15'h0000);
        ol_det[3] = 1'b1;
        sg_det[4] = 1'b1;
        wait_clk(T_DIAG + 10);
        ol_det[3] = 1'b0;
        sg_det[4] = 1'b0;
        wait_clk(5);
        read_diag(15'h4400);
        read_diag(15'h0000);
        // Masking after switch-off
        send(8'h02);
        sg_det[1] = 1'b1;
        send(8'h00);
        // Snapshot lands past the filter time but inside the mask
        wait_clk(12);
        read_diag(15'h0000);
        read_diag(15'h0020);
        sg_det[1] = 1'b0;
        check_state();
        report_and_stop();
    end
endmodule
